// ===== design/des_params.svh
`ifndef DES_PARAMS_SVH
`define DES_PARAMS_SVH

// ----------------------------------------------------------------------
// channel count and field layout
// ----------------------------------------------------------------------
`define DES_CHAN_NUM 16
`define DES_CHAN_IDX_W 4
`define DES_CC_W 3

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define DES_OFS_BUS_ERR 32'h40010048
`define DES_OFS_COMB_ERR 32'h4001004C
`define DES_OFS_INV_DESC 32'h40010050
`define DES_OFS_IRQ_STAT 32'h40010054
`define DES_OFS_IRQ_MASK 32'h40010058

// ----------------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------------
`define DES_RST_FLAGS 16'h0000
`define DES_RST_MASK 16'h0000
`define DES_CC_INVALID 3'h0
`define DES_RESP_OKAY 2'h0
`define DES_RESP_SLVERR 2'h2

`endif

// ===== design/des_pkg.sv
`include "des_params.svh"

package des_pkg;

    typedef logic [`DES_CHAN_NUM-1:0] des_chan_t;

    // write request handed from the bus slave to the register file
    typedef struct packed {
        logic fire;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } des_wr_s;

    // read request, answered in the same cycle by the register file
    typedef struct packed {
        logic fire;
        logic [31:0] addr;
    } des_rd_s;

    // bus slave state
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_held;
        logic w_held;
        logic bvalid;
        logic rvalid;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [31:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] rdata;
    } des_axs_s;

    // error tracking state
    typedef struct packed {
        des_chan_t bus_err;
        des_chan_t comb_err;
        des_chan_t inv_desc;
        des_chan_t irq_stat;
        des_chan_t irq_mask;
        des_chan_t chan_dis;
        logic irq;
    } des_st_s;

endpackage

// ===== design/des_axil.sv
`timescale 1ns/1ps
`include "des_params.svh"

module des_axil
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // write channels
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // read channels
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // register file side
    output des_pkg::des_wr_s wr_o,
    input wire logic wr_hit_i,
    output des_pkg::des_rd_s rd_o,
    input wire logic [31:0] rd_data_i,
    input wire logic rd_hit_i
);

    des_pkg::des_axs_s st_r;
    des_pkg::des_axs_s st_nxt;
    logic wr_fire;
    logic ar_take;

    // ------------------------------------------------------------------
    // handshakes: address and data held until both are present
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        ar_take = s_axi_arvalid_i & st_r.arready;
        wr_fire = st_r.aw_held & st_r.w_held & ~st_r.bvalid;
        if (s_axi_awvalid_i & st_r.awready)
        begin
            st_nxt.aw_held = 1'b1;
            st_nxt.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i & st_r.wready)
        begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = s_axi_wdata_i;
            st_nxt.wstrb = s_axi_wstrb_i;
        end
        if (st_r.bvalid & s_axi_bready_i)
            st_nxt.bvalid = 1'b0;
        if (wr_fire)
        begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_hit_i ? `DES_RESP_OKAY : `DES_RESP_SLVERR;
        end
        if (st_r.rvalid & s_axi_rready_i)
            st_nxt.rvalid = 1'b0;
        if (ar_take)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_hit_i ? rd_data_i : 32'h00000000;
            st_nxt.rresp = rd_hit_i ? `DES_RESP_OKAY : `DES_RESP_SLVERR;
        end
        // readies are registered so every bus output comes from a flop
        st_nxt.awready = ~st_nxt.aw_held & ~st_nxt.bvalid;
        st_nxt.wready = ~st_nxt.w_held & ~st_nxt.bvalid;
        st_nxt.arready = ~st_nxt.rvalid;
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready_o = st_r.awready;
    assign s_axi_wready_o = st_r.wready;
    assign s_axi_bvalid_o = st_r.bvalid;
    assign s_axi_bresp_o = st_r.bresp;
    assign s_axi_arready_o = st_r.arready;
    assign s_axi_rvalid_o = st_r.rvalid;
    assign s_axi_rresp_o = st_r.rresp;
    assign s_axi_rdata_o = st_r.rdata;
    assign wr_o = '{fire: wr_fire, addr: st_r.awaddr, data: st_r.wdata, strb: st_r.wstrb};
    assign rd_o = '{fire: ar_take, addr: s_axi_araddr_i};

endmodule

// ===== design/des_top.sv
`timescale 1ns/1ps
`include "des_params.svh"

// How it works
// [R1] a bus error on channel n sets bit n of the bus error flags
// [R2] a bus error disables only the faulted channel
// [R3] bus error flags clear on written ones; written zeros do nothing
// [R4] combined flags set on bus error or cycle control 3'b000
// [R5] either fault disables only that channel, others keep running
// [R6] combined flags clear on written ones; written zeros do nothing
// [R7] invalid descriptor flags set when a fetched cycle control is 3'b000
// [R8] an invalid cycle control disables only that channel
// [R9] invalid descriptor flags clear on written ones; zeros do nothing
// [R10] all three flag vectors are zero after reset
// [R11] bit n of every vector belongs to channel n
// [R12] bits 31 to 16 read as zero and ignore writes
module des_top
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // register bus write channels
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // register bus read channels
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // fault events from the transfer engine
    input wire logic [`DES_CHAN_NUM-1:0] bus_err_i,
    input wire logic desc_valid_i,
    input wire logic [`DES_CHAN_IDX_W-1:0] desc_chan_i,
    input wire logic [`DES_CC_W-1:0] desc_cycle_ctrl_i,
    // back to the transfer engine and the interrupt controller
    output logic [`DES_CHAN_NUM-1:0] chan_disable_o,
    output logic irq_o
);

    des_pkg::des_st_s st_r;
    des_pkg::des_st_s st_nxt;
    des_pkg::des_wr_s wr;
    des_pkg::des_rd_s rd;
    des_pkg::des_chan_t bus_ev;
    des_pkg::des_chan_t inv_ev;
    des_pkg::des_chan_t clr_bus;
    des_pkg::des_chan_t clr_comb;
    des_pkg::des_chan_t clr_inv;
    des_pkg::des_chan_t rd_clr_irq;
    des_pkg::des_chan_t flags_rd;
    logic [31:0] rd_data;
    logic wr_hit;
    logic rd_hit;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // channel index to its bit, bit n is channel n
    function automatic des_pkg::des_chan_t chan_bit(input logic [`DES_CHAN_IDX_W-1:0] idx);
        des_pkg::des_chan_t v;
        v = '0;
        v[idx] = 1'b1; // [R11]
        return v;
    endfunction

    // only the low two byte lanes hold flag bits
    function automatic des_pkg::des_chan_t lane_mask(input logic [3:0] strb);
        return {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic addr_hit(input logic [31:0] addr);
        return (addr == `DES_OFS_BUS_ERR) || (addr == `DES_OFS_COMB_ERR)
            || (addr == `DES_OFS_INV_DESC) || (addr == `DES_OFS_IRQ_STAT)
            || (addr == `DES_OFS_IRQ_MASK);
    endfunction

    // ones written to a flag register, upper bits dropped
    function automatic des_pkg::des_chan_t w1c_bits(input des_pkg::des_wr_s w,
                                                    input logic [31:0] ofs);
        if (w.fire && (w.addr == ofs))
            return w.data[`DES_CHAN_NUM-1:0] & lane_mask(w.strb); // [R12]
        else
            return '0;
    endfunction

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    des_axil u_axil
    (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .s_axi_awaddr_i(s_axi_awaddr_i),
        .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o),
        .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i),
        .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o),
        .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o),
        .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i),
        .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o),
        .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o),
        .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i),
        .wr_o(wr),
        .wr_hit_i(wr_hit),
        .rd_o(rd),
        .rd_data_i(rd_data),
        .rd_hit_i(rd_hit)
    );

    // ------------------------------------------------------------------
    // event decode and clear masks
    // ------------------------------------------------------------------

    // a descriptor with cycle control zero is a fault, anything else passes
    always_comb
    begin
        bus_ev = bus_err_i;
        inv_ev = '0;
        if (desc_valid_i && (desc_cycle_ctrl_i == `DES_CC_INVALID))
            inv_ev = chan_bit(desc_chan_i); // [R7]
        clr_bus = w1c_bits(wr, `DES_OFS_BUS_ERR); // [R3]
        clr_comb = w1c_bits(wr, `DES_OFS_COMB_ERR); // [R6]
        clr_inv = w1c_bits(wr, `DES_OFS_INV_DESC); // [R9]
        rd_clr_irq = (rd.fire && (rd.addr == `DES_OFS_IRQ_STAT)) ? '1 : '0;
        wr_hit = addr_hit(wr.addr);
        rd_hit = addr_hit(rd.addr);
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------

    // upper half always zero, so a read of any register shows 16 flag bits
    always_comb
    begin
        unique case (rd.addr)
            `DES_OFS_BUS_ERR: flags_rd = st_r.bus_err;
            `DES_OFS_COMB_ERR: flags_rd = st_r.comb_err;
            `DES_OFS_INV_DESC: flags_rd = st_r.inv_desc;
            `DES_OFS_IRQ_STAT: flags_rd = st_r.irq_stat;
            `DES_OFS_IRQ_MASK: flags_rd = st_r.irq_mask;
            default: flags_rd = '0;
        endcase
        rd_data = {16'h0000, flags_rd}; // [R12]
    end

    // ------------------------------------------------------------------
    // flag state
    // ------------------------------------------------------------------

    // a fault in the same cycle as its clear wins, so no event is lost
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.bus_err = (st_r.bus_err & ~clr_bus) | bus_ev; // [R1] [R3]
        st_nxt.comb_err = (st_r.comb_err & ~clr_comb) | bus_ev | inv_ev; // [R4] [R6]
        st_nxt.inv_desc = (st_r.inv_desc & ~clr_inv) | inv_ev; // [R7] [R9]
        // the engine sees a one-cycle disable pulse only on faulted channels
        st_nxt.chan_dis = bus_ev | inv_ev; // [R2] [R5] [R8]
        // interrupt status clears on read, again losing no event
        st_nxt.irq_stat = (st_r.irq_stat & ~rd_clr_irq) | bus_ev | inv_ev;
        if (wr.fire && (wr.addr == `DES_OFS_IRQ_MASK))
        begin
            st_nxt.irq_mask = (st_r.irq_mask & ~lane_mask(wr.strb))
                | (wr.data[`DES_CHAN_NUM-1:0] & lane_mask(wr.strb));
        end
        // computed from next values so irq_o follows status without extra lag
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    // zero reset makes every vector report no fault
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_r <= '0; // [R10]
            st_r.irq_mask <= `DES_RST_MASK;
            st_r.bus_err <= `DES_RST_FLAGS;
            st_r.comb_err <= `DES_RST_FLAGS;
            st_r.inv_desc <= `DES_RST_FLAGS;
        end
        else
            st_r <= st_nxt;
    end

    assign chan_disable_o = st_r.chan_dis;
    assign irq_o = st_r.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    a_bus_err_set: // [R1]
    assert property (bus_ev != '0 |=> (st_r.bus_err & $past(bus_ev)) == $past(bus_ev))
    else $error("bus error flag not set");

    a_bus_err_disable: // [R2]
    assert property (bus_ev != '0 |=> (chan_disable_o & $past(bus_ev)) == $past(bus_ev))
    else $error("bus error did not disable channel");

    a_bus_err_clear: // [R3]
    assert property (clr_bus != '0 && bus_ev == '0 |=> (st_r.bus_err & $past(clr_bus)) == '0)
    else $error("bus error flag not cleared by one");

    a_bus_err_hold: // [R3]
    assert property (clr_bus == '0
        |=> st_r.bus_err == ($past(st_r.bus_err) | $past(bus_ev)))
    else $error("bus error flag changed without cause");

    a_comb_set: // [R4]
    assert property ((bus_ev | inv_ev) != '0
        |=> (st_r.comb_err & $past(bus_ev | inv_ev)) == $past(bus_ev | inv_ev))
    else $error("combined flag not set");

    a_disable_only: // [R5]
    assert property (1'b1 |=> chan_disable_o == $past(bus_ev | inv_ev))
    else $error("disable reached a healthy channel");

    a_comb_clear: // [R6]
    assert property (clr_comb != '0 && (bus_ev | inv_ev) == '0
        |=> (st_r.comb_err & $past(clr_comb)) == '0)
    else $error("combined flag not cleared by one");

    a_inv_set: // [R7]
    assert property (desc_valid_i && desc_cycle_ctrl_i == `DES_CC_INVALID
        |=> st_r.inv_desc[$past(desc_chan_i)] && st_r.comb_err[$past(desc_chan_i)])
    else $error("invalid descriptor flag not set");

    a_inv_ok_desc: // [R7]
    assert property (desc_valid_i && desc_cycle_ctrl_i != `DES_CC_INVALID && clr_inv == '0
        |=> st_r.inv_desc == $past(st_r.inv_desc))
    else $error("valid descriptor raised a flag");

    a_inv_disable: // [R8]
    assert property (desc_valid_i && desc_cycle_ctrl_i == `DES_CC_INVALID
        |=> chan_disable_o[$past(desc_chan_i)] ##1 (chan_disable_o
            & ~$past(bus_ev | inv_ev) & chan_bit($past(desc_chan_i, 2))) == '0)
    else $error("invalid descriptor did not pulse disable");

    a_inv_clear: // [R9]
    assert property (clr_inv != '0 && inv_ev == '0 |=> (st_r.inv_desc & $past(clr_inv)) == '0)
    else $error("invalid descriptor flag not cleared by one");

    a_reset_zero: // [R10]
    assert property (disable iff (1'b0) $rose(resetn_i)
        |-> st_r.bus_err == '0 && st_r.comb_err == '0 && st_r.inv_desc == '0)
    else $error("flags not zero after reset");

    a_upper_zero: // [R12]
    assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");

    a_irq_follow:
    assert property (1'b1 |-> irq_o == |(st_r.irq_stat & st_r.irq_mask))
    else $error("interrupt output disagrees with status");

    // ------------------------------------------------------------------
    // register bus assertions
    // ------------------------------------------------------------------

    // a dropped answer would lose a clear or a read
    a_bresp_hold: // [R3]
    assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");

    a_rdata_hold: // [R12]
    assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read data dropped");

    a_read_answer: // [R12]
    assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o)
    else $error("read not answered");

    a_write_answer: // [R3]
    assert property (wr.fire
        |=> s_axi_bvalid_o)
    else $error("write not answered");

    // one write in flight, so nothing new is taken while a response waits
    a_write_refused: // [R3]
    assert property (s_axi_bvalid_o
        |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");

    // unmapped reads answer zero with an error, never stale data
    a_read_slverr: // [R12]
    assert property (s_axi_arvalid_i && s_axi_arready_o && !addr_hit(s_axi_araddr_i)
        |=> s_axi_rresp_o == `DES_RESP_SLVERR && s_axi_rdata_o == 32'h00000000)
    else $error("unmapped read not refused");

    a_read_okay: // [R12]
    assert property (s_axi_arvalid_i && s_axi_arready_o && addr_hit(s_axi_araddr_i)
        |=> s_axi_rresp_o == `DES_RESP_OKAY && s_axi_rdata_o[31:16] == 16'h0000)
    else $error("mapped read not okay");

    a_write_slverr: // [R12]
    assert property (wr.fire && !addr_hit(wr.addr)
        |=> s_axi_bresp_o == `DES_RESP_SLVERR)
    else $error("unmapped write not refused");

    // a full-strobe mask write replaces all sixteen enables
    a_mask_write:
    assert property (wr.fire && wr.addr == `DES_OFS_IRQ_MASK && wr.strb == 4'hF
        |=> st_r.irq_mask == $past(wr.data[`DES_CHAN_NUM-1:0]))
    else $error("mask write did not land");

    // read-clear, unless a fault lands in that same cycle
    a_stat_rd_clear:
    assert property (rd.fire && rd.addr == `DES_OFS_IRQ_STAT && (bus_ev | inv_ev) == '0
        |=> st_r.irq_stat == '0)
    else $error("interrupt status not cleared by read");

    a_comb_hold: // [R6]
    assert property (clr_comb == '0
        |=> st_r.comb_err == ($past(st_r.comb_err) | $past(bus_ev | inv_ev)))
    else $error("combined flag changed without cause");

    c_bus_err: cover property (bus_ev != '0 ##1 chan_disable_o != '0);
    c_inv_desc: cover property (inv_ev != '0 ##1 st_r.inv_desc != '0);
    c_w1c: cover property (clr_comb != '0 ##1 st_r.comb_err == '0);
    c_irq: cover property ($rose(irq_o));
    c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == `DES_RESP_SLVERR);

endmodule

// ===== test/des_fault_src.sv
`timescale 1ns/1ps
`include "des_params.svh"

// ------------------------------------------------
// fault event source in place of the transfer engine
// ------------------------------------------------
module des_fault_src
(
    // clock
    input wire logic mclk_i,
    // fault events
    output logic [`DES_CHAN_NUM-1:0] bus_err_o,
    output logic desc_valid_o,
    output logic [`DES_CHAN_IDX_W-1:0] desc_chan_o,
    output logic [`DES_CC_W-1:0] desc_cc_o
);
    // quiet at time zero
    initial
    begin
        bus_err_o = 16'h0000;
        desc_valid_o = 1'b0;
        desc_chan_o = 4'h0;
        desc_cc_o = 3'h0;
    end

    // one event cycle after an idle gap; descriptor fields are inverted
    // afterwards so a decoder that ignores the strobe gets caught
    task automatic fire(input logic [15:0] be, input logic dv, input logic [3:0] ch,
                        input logic [2:0] cc, input int gap);
        repeat (gap) @(posedge mclk_i);
        @(posedge mclk_i);
        bus_err_o <= be;
        desc_valid_o <= dv;
        desc_chan_o <= ch;
        desc_cc_o <= cc;
        @(posedge mclk_i);
        bus_err_o <= 16'h0000;
        desc_valid_o <= 1'b0;
        desc_chan_o <= ~ch;
        desc_cc_o <= ~cc;
    endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
`include "des_params.svh"

module testbench;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [31:0] awaddr = 32'h00000000, wdata = 32'h00000000, araddr = 32'h00000000, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, dvalid;
    logic [1:0] bresp, rresp;
    logic [15:0] bus_err, dis, bus_m, comb_m, inv_m, ist_m, mask_m, be;
    logic [3:0] dchan;
    logic [2:0] dcc;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [15:0] dq[$];
    logic [31:0] v;
    int n_fail = 0, compares = 0, i, seed;

    // ------------------------------------------------
    // clock, design and fault source
    // ------------------------------------------------
    always #12.5 mclk_i = ~mclk_i;

    des_top DUT (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .bus_err_i(bus_err),
        .desc_valid_i(dvalid), .desc_chan_i(dchan), .desc_cycle_ctrl_i(dcc),
        .chan_disable_o(dis), .irq_o(irq));

    des_fault_src u_src (.mclk_i(mclk_i), .bus_err_o(bus_err), .desc_valid_o(dvalid),
        .desc_chan_o(dchan), .desc_cc_o(dcc));

    // ------------------------------------------------
    // checking and verdict
    // ------------------------------------------------
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // results are compared in the cycle the handshake completes
    always @(posedge mclk_i)
    begin
        if (resetn_i && rvalid && rready)
            check("read", {rresp, rdata}, rq.pop_front());
        if (resetn_i && bvalid && bready)
            check("bresp", {32'h00000000, bresp}, {32'h00000000, bq.pop_front()});
        if (resetn_i && dis !== 16'h0000)
            check("disable", {18'h00000, dis}, {18'h00000, dq.pop_front()});
    end

    // ------------------------------------------------
    // bus master and fault stimulus
    // ------------------------------------------------
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        bq.push_back(r);
        @(posedge mclk_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100 && !(bvalid && bready); n++)
        begin
            @(posedge mclk_i);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (n == 100)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask

    task automatic axi_read(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        rq.push_back({r, d});
        @(posedge mclk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100 && !(rvalid && rready); n++)
        begin
            @(posedge mclk_i);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (n == 100)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask

    // expected flags follow the event at once; the pulse is queued for the monitor
    task automatic fault(input logic [15:0] b, input logic [3:0] ch, input logic [2:0] cc,
                         input int gap);
        logic [15:0] dv;
        dv = (cc == `DES_CC_INVALID) ? (16'h0001 << ch) : 16'h0000;
        bus_m |= b;
        inv_m |= dv;
        comb_m |= b | dv;
        ist_m |= b | dv;
        if ((b | dv) != 16'h0000)
            dq.push_back(b | dv);
        u_src.fire(b, 1'b1, ch, cc, gap);
        @(negedge mclk_i);
        check("irq", {33'h0, irq}, {33'h0, |(ist_m & mask_m)});
    endtask

    task automatic rd_all();
        axi_read(`DES_OFS_BUS_ERR, {16'h0000, bus_m}, `DES_RESP_OKAY);
        axi_read(`DES_OFS_COMB_ERR, {16'h0000, comb_m}, `DES_RESP_OKAY);
        axi_read(`DES_OFS_INV_DESC, {16'h0000, inv_m}, `DES_RESP_OKAY);
    endtask

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        seed = $urandom(32);
        {bus_m, comb_m, inv_m, ist_m, mask_m} = 80'h0;
        repeat (10) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rd_all();
        axi_read(`DES_OFS_IRQ_STAT, 32'h00000000, `DES_RESP_OKAY);
        axi_read(32'h4001005C, 32'h00000000, `DES_RESP_SLVERR);
        axi_write(32'h40010044, 32'hFFFFFFFF, `DES_RESP_SLVERR);
        // masked faults must keep the interrupt low
        fault(16'h0001, 4'h0, 3'h1, 0);
        v = $urandom;
        mask_m = v[15:0];
        axi_write(`DES_OFS_IRQ_MASK, v, `DES_RESP_OKAY);
        axi_read(`DES_OFS_IRQ_MASK, {16'h0000, mask_m}, `DES_RESP_OKAY);
        // every cycle-control code, mixed with random bus errors and gaps
        for (i = 0; i < 24; i++)
        begin
            v = $urandom;
            be = (i < 8) ? 16'h0000 : v[31:16];
            fault(be, v[3:0], i[0] ? 3'h0 : i[3:1], i % 3);
        end
        rd_all();
        // reading the interrupt status empties it and drops the line
        axi_read(`DES_OFS_IRQ_STAT, {16'h0000, ist_m}, `DES_RESP_OKAY);
        ist_m = 16'h0000;
        @(negedge mclk_i);
        check("irq", {33'h0, irq}, 34'h0);
        // ones clear, zeros and the upper half do nothing
        for (i = 0; i < 3; i++)
        begin
            v = $urandom;
            axi_write(`DES_OFS_BUS_ERR + 4 * i, v, `DES_RESP_OKAY);
            axi_write(`DES_OFS_BUS_ERR + 4 * i, 32'h00000000, `DES_RESP_OKAY);
            if (i == 0)
                bus_m &= ~v[15:0];
            if (i == 1)
                comb_m &= ~v[15:0];
            if (i == 2)
                inv_m &= ~v[15:0];
            rd_all();
        end
        // a second reset in mid-run empties everything again
        fault(16'h8001, 4'h5, 3'h0, 1);
        @(posedge mclk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        resetn_i <= 1'b1;
        {bus_m, comb_m, inv_m, ist_m, mask_m} = 80'h0;
        rd_all();
        repeat (4) @(posedge mclk_i);
        check("left", {2'h0, rq.size() + bq.size() + dq.size()}, 34'h0);
        report_and_stop();
    end
endmodule
